// ==== pkg/epc_defs.svh ====
// Constants of the serial EEPROM protection and read logic
`ifndef EPC_DEFS_SVH
`define EPC_DEFS_SVH

// Control byte type nibbles
`define EPC_TYPE_MEM 4'hA
`define EPC_TYPE_PROT 4'h6
// Whole control byte that clears all protection
`define EPC_CTL_CLEAR 8'h66
// Quadrant identifier codes
`define EPC_QID_Q0 3'h1
`define EPC_QID_Q1 3'h4
`define EPC_QID_Q2 3'h5
`define EPC_QID_Q3 3'h0
`define EPC_QID_CLEAR 3'h3
// Array size in bytes, two halves of 256
`define EPC_MEM_BYTES 512
// Master bit timing: quarter of one serial clock period
`define EPC_CLK_NS 10
`define EPC_QTR_NS 250
`define EPC_QTR_CYC ((`EPC_QTR_NS + `EPC_CLK_NS - 1) / `EPC_CLK_NS)
// Received data buffer of the master
`define EPC_FIFO_WIDTH 8
`define EPC_FIFO_DEPTH 32

`endif

// ==== pkg/epc_pkg.sv ====
// Types and helper functions shared by both ends of the serial link
`include "epc_defs.svh"
package epc_pkg;

  // Level of address pin 0, which may be raised above the supply
  typedef enum logic [1:0] {
    EPC_PIN0_LOW,
    EPC_PIN0_HIGH,
    EPC_PIN0_HV
  } epc_pin0_t;

  // Operations the master can run
  typedef enum logic [2:0] {
    OP_CUR_READ,
    OP_RAND_READ,
    OP_WRITE,
    OP_CLEAR,
    OP_SET,
    OP_QUERY
  } epc_op_t;

  // Kind of sequence the target has recognised
  typedef enum logic [2:0] {
    K_NONE,
    K_MEM_W,
    K_MEM_R,
    K_CLEAR,
    K_SET,
    K_QUERY
  } epc_kind_t;

  // Maps a quadrant identifier to a flag index
  function automatic logic [1:0] epc_quad_index(input logic [2:0] id);
    case (id)
      `EPC_QID_Q0: epc_quad_index = 2'h0;
      `EPC_QID_Q1: epc_quad_index = 2'h1;
      `EPC_QID_Q2: epc_quad_index = 2'h2;
      default: epc_quad_index = 2'h3;
    endcase
  endfunction

  // True for the four identifiers that name a quadrant
  function automatic logic epc_quad_valid(input logic [2:0] id);
    epc_quad_valid = (id == `EPC_QID_Q0) || (id == `EPC_QID_Q1) ||
                     (id == `EPC_QID_Q2) || (id == `EPC_QID_Q3);
  endfunction

endpackage

// ==== pkg/epc_bus_if.sv ====
// Two-wire link between master and target, with resolved open-drain lines
interface epc_bus_if;
  logic scl_o_h;
  logic scl_oe_h;
  logic sda_o_h;
  logic sda_oe_h;
  logic sda_o_d;
  logic sda_oe_d;
  epc_pkg::epc_pin0_t address_pin_0;
  logic address_pin_1;
  logic address_pin_2;
  logic scl;
  logic sda;

  // Wired-AND of the drivers, pulled high when nobody drives
  assign scl = scl_oe_h ? scl_o_h : 1'b1;
  assign sda = (sda_oe_h ? sda_o_h : 1'b1) & (sda_oe_d ? sda_o_d : 1'b1);

  modport target (
    input scl, sda, address_pin_0, address_pin_1, address_pin_2,
    output sda_o_d, sda_oe_d
  );

  modport master (
    input scl, sda,
    output scl_o_h, scl_oe_h, sda_o_h, sda_oe_h,
    output address_pin_0, address_pin_1, address_pin_2
  );
endinterface

// ==== hw/epc_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides
module epc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [0:DEPTH-1];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready = !((wr_q[AW] != rd_q[AW]) &&
                      (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = wr_q != rd_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q[AW-1:0]];

  // Pointer update
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end

  // Storage write
  always_ff @(posedge clk) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule

// ==== hw/epc_target.sv ====
// Serial EEPROM target: protection clear, status query and memory reads
// Overview of operation
// - Clear control byte 66h write is acknowledged
// - Clear address and data bytes: any answer
// - Address pin 0 held high voltage throughout
// - Master ends clear with Stop after data
// - Clear removes all quadrant protection at once
// - Status query control byte is 0110 id 1
// - Query accepted at any address pin 0 level
// - Unprotected: ACK control, NACK next two bytes
// - Protected: NACK all three query bytes
// - Read control 1010, pins match, ACK next
// - Current read sends counter byte, then increments counter
// - Counter wraps inside selected half only
// - Master ends read with NACK then Stop
// - Random read: dummy write, repeated Start, read
// - Continue sending bytes while master acknowledges
// - Master selects half before reading
// - Identifiers 001, 100, 101, 000 name quadrants
// - Set control 0110 id 0 with high voltage
`include "epc_defs.svh"
module epc_target (
  input wire logic clk,
  input wire logic rstn,
  epc_bus_if.target bus,
  input wire logic half_select,
  output logic [3:0] reversible_write_protect
);
  typedef enum logic [2:0] {
    D_IDLE,
    D_RX,
    D_PRE,
    D_ACK,
    D_TX,
    D_TXACK
  } epc_dstate_t;

  epc_dstate_t state_q;
  epc_pkg::epc_kind_t kind_q;
  epc_pkg::epc_kind_t kind_d;
  logic scl_q;
  logic sda_q;
  logic rise;
  logic fall;
  logic start_ev;
  logic stop_ev;
  logic [6:0] shift_q;
  logic [7:0] rx_byte;
  logic [2:0] bit_q;
  logic [1:0] byte_q;
  logic ack_q;
  logic ack_d;
  logic m_ack_q;
  logic hv_ok_q;
  logic wr_pend_q;
  logic rx_done;
  logic tx_load;
  logic commit;
  logic pin0_bit;
  logic [7:0] tx_q;
  logic [7:0] ctr_q;
  logic [7:0] wdata_q;
  logic [1:0] quad_q;
  logic [1:0] quad_d;
  logic [3:0] prot_q;
  logic [8:0] mem_idx;
  logic [7:0] mem [0:`EPC_MEM_BYTES-1];

  // Bus line history for edge and condition detection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= bus.scl;
      sda_q <= bus.sda;
    end
  end

  // Edges of the serial clock, Start and Stop conditions
  assign rise = bus.scl && !scl_q;
  assign fall = !bus.scl && scl_q;
  assign start_ev = bus.scl && scl_q && sda_q && !bus.sda;
  assign stop_ev = bus.scl && scl_q && !sda_q && bus.sda;

  // Both high levels of address pin 0 count as a one for addressing
  assign pin0_bit = bus.address_pin_0 != epc_pkg::EPC_PIN0_LOW;
  assign rx_byte = {shift_q, bus.sda};
  assign rx_done = (state_q == D_RX) && rise && (bit_q == 3'h7);
  assign mem_idx = {half_select, ctr_q};
  assign tx_load = fall && (((state_q == D_ACK) &&
                   (kind_q == epc_pkg::K_MEM_R)) ||
                   ((state_q == D_TXACK) && m_ack_q));
  assign commit = stop_ev && (kind_q == epc_pkg::K_MEM_W) && wr_pend_q;

  // Decode of each received byte and the answer it earns
  always_comb begin
    kind_d = kind_q;
    ack_d = 1'b0;
    quad_d = quad_q;
    if (byte_q == 2'h0) begin
      kind_d = epc_pkg::K_NONE;
      if (rx_byte[7:4] == `EPC_TYPE_MEM && rx_byte[3:1] ==
          {bus.address_pin_2, bus.address_pin_1, pin0_bit}) begin
        kind_d = rx_byte[0] ? epc_pkg::K_MEM_R : epc_pkg::K_MEM_W;
        ack_d = 1'b1;
      end else if (rx_byte[7:4] == `EPC_TYPE_PROT) begin
        quad_d = epc_pkg::epc_quad_index(rx_byte[3:1]);
        if (rx_byte == `EPC_CTL_CLEAR) begin
          kind_d = epc_pkg::K_CLEAR;
          ack_d = 1'b1;
        end else if (epc_pkg::epc_quad_valid(rx_byte[3:1])) begin
          kind_d = rx_byte[0] ? epc_pkg::K_QUERY : epc_pkg::K_SET;
          ack_d = rx_byte[0] ? !prot_q[quad_d] : 1'b1;
        end
      end
    end else if (byte_q != 2'h3) begin
      ack_d = (kind_q == epc_pkg::K_MEM_W) ||
              (kind_q == epc_pkg::K_CLEAR) ||
              (kind_q == epc_pkg::K_SET);
    end
  end

  // Protocol sequencer; a refused byte drops back to idle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= D_IDLE;
      bit_q <= 3'h0;
      byte_q <= 2'h0;
      shift_q <= 7'h00;
      kind_q <= epc_pkg::K_NONE;
      ack_q <= 1'b0;
      quad_q <= 2'h0;
      m_ack_q <= 1'b0;
    end else if (start_ev) begin
      // repeated Start restarts the byte count
      state_q <= D_RX;
      bit_q <= 3'h0;
      byte_q <= 2'h0;
      kind_q <= epc_pkg::K_NONE;
    end else if (stop_ev) begin
      state_q <= D_IDLE;
    end else begin
      unique case (state_q)
        D_IDLE: begin
          bit_q <= 3'h0;
        end
        D_RX: begin
          if (rise) begin
            shift_q <= rx_byte[6:0];
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              state_q <= D_PRE;
              ack_q <= ack_d;
              kind_q <= kind_d;
              quad_q <= quad_d;
            end
          end
        end
        D_PRE: begin
          // Wait for clock low before touching the data line
          if (fall) state_q <= D_ACK;
        end
        D_ACK: begin
          if (fall) begin
            if (byte_q != 2'h3) byte_q <= byte_q + 2'h1;
            bit_q <= 3'h0;
            if (!ack_q) begin
              state_q <= D_IDLE;
            end else if (kind_q == epc_pkg::K_MEM_R) begin
              state_q <= D_TX;
            end else begin
              state_q <= D_RX;
            end
          end
        end
        D_TX: begin
          if (fall) begin
            if (bit_q == 3'h7) state_q <= D_TXACK;
            else bit_q <= bit_q + 3'h1;
          end
        end
        D_TXACK: begin
          // master ACK asks for another byte
          if (rise) begin
            m_ack_q <= !bus.sda;
          end else if (fall) begin
            bit_q <= 3'h0;
            state_q <= m_ack_q ? D_TX : D_IDLE;
          end
        end
      endcase
    end
  end

  // Transmit shift register, loaded from the array at the counter
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_q <= 8'h00;
    end else if (tx_load) begin
      tx_q <= mem[mem_idx];
    end else if (state_q == D_TX && fall) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // Address counter: 8 bits, the half comes from half_select
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctr_q <= 8'h00;
    end else if (tx_load) begin
      // eight-bit wrap stays in the half
      ctr_q <= ctr_q + 8'h01;
    end else if (rx_done && kind_q == epc_pkg::K_MEM_W &&
                 byte_q == 2'h1) begin
      ctr_q <= rx_byte;
    end else if (commit) begin
      ctr_q <= ctr_q + 8'h01;
    end
  end

  // Pending write data, held until the Stop that commits it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wdata_q <= 8'h00;
      wr_pend_q <= 1'b0;
    end else if (start_ev || stop_ev) begin
      wr_pend_q <= 1'b0;
    end else if (rx_done && kind_q == epc_pkg::K_MEM_W &&
                 byte_q == 2'h2) begin
      wdata_q <= rx_byte;
      wr_pend_q <= 1'b1;
    end
  end

  // Array write, skipped for a protected quadrant
  always_ff @(posedge clk) begin
    if (commit && !prot_q[{half_select, ctr_q[7]}]) begin
      mem[mem_idx] <= wdata_q;
    end
  end

  // High voltage must stand on pin 0 from Start to Stop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hv_ok_q <= 1'b0;
    end else if (start_ev) begin
      hv_ok_q <= bus.address_pin_0 == epc_pkg::EPC_PIN0_HV;
    end else if (bus.address_pin_0 != epc_pkg::EPC_PIN0_HV) begin
      // lost high voltage voids the command
      hv_ok_q <= 1'b0;
    end
  end

  // Protection flags, acted on at the Stop after the data byte
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prot_q <= 4'h0;
    end else if (stop_ev && hv_ok_q && byte_q == 2'h3) begin
      if (kind_q == epc_pkg::K_CLEAR) begin
        prot_q <= 4'h0;
      end else if (kind_q == epc_pkg::K_SET) begin
        prot_q[quad_q] <= 1'b1;
      end
    end
  end

  // Open-drain data output: drive low for ACK and zero bits
  assign bus.sda_o_d = 1'b0;
  assign bus.sda_oe_d = ((state_q == D_ACK) && ack_q) ||
                        ((state_q == D_TX) && !tx_q[7]);
  assign reversible_write_protect = prot_q;
endmodule

// ==== hw/epc_host.sv ====
// Two-wire master that runs reads and protection commands
`include "epc_defs.svh"
module epc_host (
  input wire logic clk,
  input wire logic rstn,
  epc_bus_if.master bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire epc_pkg::epc_op_t cmd_op,
  input wire logic [7:0] cmd_addr,
  input wire logic [2:0] cmd_quad,
  input wire logic [7:0] cmd_data,
  input wire logic [7:0] cmd_len,
  input wire logic strap_pin_0,
  input wire logic strap_pin_1,
  input wire logic strap_pin_2,
  output logic done,
  output logic [2:0] ack_bits,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data
);
  typedef enum logic [1:0] {
    ACT_START,
    ACT_WR,
    ACT_RD,
    ACT_STOP
  } epc_act_t;

  epc_act_t act;
  epc_pkg::epc_op_t op_q;
  logic busy_q;
  logic done_q;
  logic [7:0] addr_q;
  logic [2:0] quad_q;
  logic [7:0] data_q;
  logic [7:0] rd_cnt_q;
  logic [2:0] step_q;
  logic [3:0] slot_q;
  logic [1:0] ph_q;
  logic [4:0] cnt_q;
  logic [7:0] rsh_q;
  logic [2:0] ack_q;
  logic [7:0] wbyte;
  logic [6:0] dev;
  logic tick;
  logic stall;
  logic push;
  logic fifo_ready;
  logic hv_op;

  assign dev = {`EPC_TYPE_MEM, strap_pin_2, strap_pin_1, strap_pin_0};
  assign hv_op = (op_q == epc_pkg::OP_CLEAR) || (op_q == epc_pkg::OP_SET);

  // Element of the sequence at the current step, and its byte
  always_comb begin
    act = ACT_STOP;
    wbyte = 8'h00;
    if (op_q == epc_pkg::OP_CUR_READ) begin
      case (step_q)
        3'h0: act = ACT_START;
        3'h1: begin act = ACT_WR; wbyte = {dev, 1'b1}; end
        3'h2: act = ACT_RD;
        default: act = ACT_STOP;
      endcase
    end else if (op_q == epc_pkg::OP_RAND_READ) begin
      case (step_q)
        3'h0, 3'h3: act = ACT_START;
        3'h1: begin act = ACT_WR; wbyte = {dev, 1'b0}; end
        3'h2: begin act = ACT_WR; wbyte = addr_q; end
        3'h4: begin act = ACT_WR; wbyte = {dev, 1'b1}; end
        3'h5: act = ACT_RD;
        default: act = ACT_STOP;
      endcase
    end else begin
      case (step_q)
        3'h0: act = ACT_START;
        3'h1: begin
          act = ACT_WR;
          case (op_q)
            epc_pkg::OP_WRITE: wbyte = {dev, 1'b0};
            epc_pkg::OP_CLEAR: wbyte = `EPC_CTL_CLEAR;
            epc_pkg::OP_SET: wbyte = {`EPC_TYPE_PROT, quad_q, 1'b0};
            default: wbyte = {`EPC_TYPE_PROT, quad_q, 1'b1};
          endcase
        end
        3'h2: begin act = ACT_WR; wbyte = addr_q; end
        3'h3: begin act = ACT_WR; wbyte = data_q; end
        default: act = ACT_STOP;
      endcase
    end
  end

  // Quarter-period timer; holds while the read buffer is full
  assign tick = cnt_q == 5'(`EPC_QTR_CYC - 1);
  assign stall = (act == ACT_RD) && (slot_q == 4'h0) && (ph_q == 2'h0) &&
                 !fifo_ready;
  assign push = busy_q && tick && (act == ACT_RD) && (slot_q == 4'h7) &&
                (ph_q == 2'h3);

  // Command intake and bit sequencing
  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      op_q <= epc_pkg::OP_CUR_READ;
      addr_q <= 8'h00;
      quad_q <= 3'h0;
      data_q <= 8'h00;
      rd_cnt_q <= 8'h01;
      step_q <= 3'h0;
      slot_q <= 4'h0;
      ph_q <= 2'h0;
      cnt_q <= 5'h00;
      rsh_q <= 8'h00;
      ack_q <= 3'h0;
    end else if (!busy_q) begin
      done_q <= 1'b0;
      cnt_q <= 5'h00;
      if (cmd_valid) begin
        busy_q <= 1'b1;
        op_q <= cmd_op;
        addr_q <= cmd_addr;
        quad_q <= cmd_quad;
        data_q <= cmd_data;
        rd_cnt_q <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
        step_q <= 3'h0;
        slot_q <= 4'h0;
        ph_q <= 2'h0;
        ack_q <= 3'h0;
      end
    end else if (stall) begin
      cnt_q <= 5'h00;
    end else if (!tick) begin
      cnt_q <= cnt_q + 5'h01;
    end else begin
      cnt_q <= 5'h00;
      ph_q <= ph_q + 2'h1;
      // Sample the data line while the clock is high
      if (ph_q == 2'h2 && act == ACT_WR && slot_q == 4'h8) begin
        ack_q <= {ack_q[1:0], !bus.sda};
      end
      if (ph_q == 2'h2 && act == ACT_RD && slot_q != 4'h8) begin
        rsh_q <= {rsh_q[6:0], bus.sda};
      end
      if (ph_q == 2'h3) begin
        if (act == ACT_START) begin
          step_q <= step_q + 3'h1;
        end else if (act == ACT_STOP) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else if (slot_q != 4'h8) begin
          slot_q <= slot_q + 4'h1;
        end else begin
          slot_q <= 4'h0;
          if (act == ACT_WR || rd_cnt_q == 8'h01) step_q <= step_q + 3'h1;
          if (act == ACT_RD) rd_cnt_q <= rd_cnt_q - 8'h01;
        end
      end
    end
  end

  // Line drive by phase: 0 clock low, 1-2 high, 3 low except in Stop
  assign bus.scl_o_h = 1'b0;
  assign bus.sda_o_h = 1'b0;
  assign bus.scl_oe_h = busy_q && ((ph_q == 2'h0) ||
                        ((ph_q == 2'h3) && (act != ACT_STOP)));
  always_comb begin
    case (act)
      ACT_START: bus.sda_oe_h = busy_q && ph_q[1];
      ACT_STOP: bus.sda_oe_h = busy_q && !ph_q[1];
      ACT_WR: bus.sda_oe_h = busy_q && (slot_q != 4'h8) &&
                             !wbyte[3'h7 - slot_q[2:0]];
      // ACK all but the last byte
      default: bus.sda_oe_h = busy_q && (slot_q == 4'h8) &&
                              (rd_cnt_q != 8'h01);
    endcase
  end

  // Address pins: high voltage on pin 0 only for clear and set
  // pin 0 raised for the whole sequence
  assign bus.address_pin_0 = (busy_q && hv_op) ? epc_pkg::EPC_PIN0_HV :
                             (strap_pin_0 ? epc_pkg::EPC_PIN0_HIGH :
                              epc_pkg::EPC_PIN0_LOW);
  assign bus.address_pin_1 = strap_pin_1;
  assign bus.address_pin_2 = strap_pin_2;
  assign cmd_ready = !busy_q;
  assign done = done_q;
  assign ack_bits = ack_q;

  // Received bytes wait here for the user
  epc_fifo #(
    .WIDTH(`EPC_FIFO_WIDTH),
    .DEPTH(`EPC_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(rsh_q),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );
endmodule

// ==== verif/epc_link_asserts.sv ====
// Protocol checks on the two-wire link between host and target ends
module epc_link_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe_h,
  input wire logic sda_oe_h,
  input wire logic sda_oe_d,
  input wire epc_pkg::epc_pin0_t address_pin_0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] low_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Cycles the clock line has stayed low, saturating
  always_ff @(posedge clk) begin
    if (!rstn || scl)
      low_q <= 8'h00;
    else if (low_q != 8'hFF)
      low_q <= low_q + 8'h01;
  end
  a_low_span: assert property ($rose(scl) |-> low_q >= 8'h14)
    else $error("clock low stretch too short");
  a_data_steady: assert property (
    scl && $past(scl) |-> $stable(sda_oe_d))
    else $error("target moved data while clock high");
  a_drive_fall: assert property (
    $rose(sda_oe_d) |-> !$past(scl) && $past(scl, 2))
    else $error("target drive not one cycle after fall");
  a_release_fall: assert property (
    $fell(sda_oe_d) |-> !$past(scl) && $past(scl, 2))
    else $error("target release not one cycle after fall");
  a_start_host: assert property (
    scl && $past(scl) && $fell(sda) |-> sda_oe_h)
    else $error("start not made by host");
  a_no_fight: assert property (scl |-> !(sda_oe_d && sda_oe_h))
    else $error("both ends pull data while clock high");
  a_stop_quiet: assert property (
    scl && $past(scl) && $rose(sda) |=> !sda_oe_d [*8])
    else $error("target drives right after stop");
  a_pin0_steady: assert property (
    $changed(address_pin_0) |-> !$past(scl_oe_h) && !$past(sda_oe_h))
    else $error("pin 0 level changed inside a sequence");
endmodule

// ==== verif/test_eeprom_protect_clear_and_read.sv ====
// Bench joining both ends of the EEPROM link over one interface
`include "epc_defs.svh"
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("ERROR %0t: got %h exp %h", $time, got, exp); \
    end \
  end
module test_eeprom_protect_clear_and_read;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  epc_pkg::epc_op_t cmd_op = epc_pkg::OP_CUR_READ;
  logic [7:0] cmd_addr = 8'h00;
  logic [2:0] cmd_quad = 3'h0;
  logic [7:0] cmd_data = 8'h00;
  logic [7:0] cmd_len = 8'h01;
  logic [2:0] strap = 3'h5;
  logic half_select = 1'b0;
  logic rd_ready = 1'b0;
  logic done;
  logic [2:0] ack_bits;
  logic rd_valid;
  logic [7:0] rd_data;
  logic [3:0] prot;
  logic [2:0] qid [4] = '{`EPC_QID_Q0, `EPC_QID_Q1, `EPC_QID_Q2,
                          `EPC_QID_Q3};
  int mismatches = 0;
  int cmp_count = 0;
  epc_bus_if bus();
  // Free-running system clock
  always #5 clk = ~clk;
  epc_host u_epc_host (
    .clk(clk), .rstn(rstn), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_quad(cmd_quad), .cmd_data(cmd_data), .cmd_len(cmd_len),
    .strap_pin_0(strap[0]), .strap_pin_1(strap[1]),
    .strap_pin_2(strap[2]), .done(done), .ack_bits(ack_bits),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data)
  );
  epc_target u_epc_target (
    .clk(clk), .rstn(rstn), .bus(bus), .half_select(half_select),
    .reversible_write_protect(prot)
  );
  epc_link_asserts u_epc_link_asserts (
    .clk(clk), .rstn(rstn), .scl(bus.scl), .sda(bus.sda),
    .scl_oe_h(bus.scl_oe_h), .sda_oe_h(bus.sda_oe_h),
    .sda_oe_d(bus.sda_oe_d), .address_pin_0(bus.address_pin_0)
  );
  // Hands one command to the host; taken at the next edge
  task automatic issue(input epc_pkg::epc_op_t op, input logic [7:0] a,
                       input logic [2:0] q, input logic [7:0] d,
                       input logic [7:0] n);
    @(posedge clk);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_quad <= q;
    cmd_data <= d;
    cmd_len <= n;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask
  // Waits for the completion pulse under a bound
  task automatic wait_done();
    int i;
    for (i = 0; i < 40000 && done !== 1'b1; i++) @(negedge clk);
    if (done !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t: no completion", $time);
    end
  endtask
  task automatic run(input epc_pkg::epc_op_t op, input logic [7:0] a,
                     input logic [2:0] q, input logic [7:0] d);
    issue(op, a, q, d, 8'h01);
    wait_done();
  endtask
  // Takes one word from the read buffer
  task automatic pop(output logic [7:0] v);
    int i;
    @(negedge clk);
    for (i = 0; i < 20000 && rd_valid !== 1'b1; i++) @(negedge clk);
    v = rd_data;
    @(posedge clk);
    rd_ready <= 1'b1;
    @(posedge clk);
    rd_ready <= 1'b0;
  endtask
  // Writes known bytes around the top of the lower half
  task automatic t_seq();
    logic [7:0] v;
    int i;
    half_select <= 1'b1;
    run(epc_pkg::OP_WRITE, 8'h00, 3'h0, 8'hC3);
    @(posedge clk);
    half_select <= 1'b0;
    for (i = 0; i < 4; i++)
      run(epc_pkg::OP_WRITE, 8'hFE + 8'(i), 3'h0, (8'hFE + 8'(i)) ^ 8'h5A);
    issue(epc_pkg::OP_RAND_READ, 8'hFE, 3'h0, 8'h00, 8'h21);
    i = 0;
    for (int k = 0; k < 60000 && i < 300; k++) begin
      @(negedge clk);
      i = bus.scl ? 0 : i + 1;
    end
    `CHK(rd_valid, 1'b1)
    `CHK(done, 1'b0)
    `CHK(cmd_ready, 1'b0)
    for (i = 0; i < 33; i++) begin
      pop(v);
      if (i < 4)
        `CHK(v, (8'hFE + 8'(i)) ^ 8'h5A)
    end
    wait_done();
    $display("t_seq finished");
  endtask
  // Random read then current address read across the wrap
  task automatic t_cur();
    logic [7:0] v;
    run(epc_pkg::OP_RAND_READ, 8'hFF, 3'h0, 8'h00);
    pop(v);
    `CHK(v, 8'hA5)
    run(epc_pkg::OP_CUR_READ, 8'h00, 3'h0, 8'h00);
    pop(v);
    `CHK(v, 8'h5A)
    $display("t_cur finished");
  endtask
  // Sets every quadrant, queries, clears all at once
  task automatic t_prot();
    for (int i = 0; i < 4; i++) begin
      run(epc_pkg::OP_SET, 8'h00, qid[i], 8'h00);
      `CHK(prot[i], 1'b1)
    end
    run(epc_pkg::OP_QUERY, 8'h11, qid[0], 8'h22);
    `CHK(ack_bits, 3'h0)
    run(epc_pkg::OP_CLEAR, 8'hA5, `EPC_QID_CLEAR, 8'h3C);
    `CHK(ack_bits[2], 1'b1)
    `CHK(prot, 4'h0)
    for (int i = 0; i < 4; i++) begin
      run(epc_pkg::OP_QUERY, 8'h33, qid[i], 8'h44);
      `CHK(ack_bits, 3'h4)
    end
    // Query with address pin 0 held low
    @(posedge clk);
    strap <= 3'h4;
    run(epc_pkg::OP_QUERY, 8'h55, qid[1], 8'h66);
    `CHK(ack_bits, 3'h4)
    @(posedge clk);
    strap <= 3'h5;
    $display("t_prot finished");
  endtask
  // Prints the counts and the verdict, then stops
  task automatic results();
    $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_seq();
    t_cur();
    t_prot();
    results();
  end
  // Watchdog a little beyond the planned run of about 86000 cycles
  initial begin
    #990000;
    mismatches++;
    results();
  end
endmodule
